/* File: logic/starter_li_pkg.sv */
// Purpose: Shared constants and types for the starter logic-input block
// Assumes: 200 MHz mclk, classic Wishbone slave with 32-bit data
// Notes:   Register offsets are byte addresses of aligned words
package starter_li_pkg;

  // Clock rate and long timing figures
  localparam longint unsigned CLK_HZ          = 64'd200_000_000;
  localparam longint unsigned CONFIRM_HOLD_S  = 64'd10;
  localparam longint unsigned MINUTE_S        = 64'd60;
  localparam logic [31:0]     CONFIRM_HOLD_CYC =
    32'(CLK_HZ * CONFIRM_HOLD_S);
  localparam logic [35:0]     MINUTE_CYC       = 36'(CLK_HZ * MINUTE_S);

  // Register offsets
  localparam logic [3:0] CONFIG_OFS  = 4'h0;
  localparam logic [3:0] PREHEAT_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS  = 4'h8;
  localparam logic [3:0] FAULT_OFS   = 4'hc;

  // CONFIG fields
  localparam int CFG_A_LSB   = 0;
  localparam int CFG_B_LSB   = 4;
  localparam int CFG_CSC_BIT = 8;
  localparam int CFG_ISO_BIT = 9;

  // PREHEAT fields and limits
  localparam int          PH_LEVEL_LSB = 0;
  localparam int          PH_DELAY_LSB = 16;
  localparam logic [6:0]  LEVEL_MAX    = 7'h64;
  localparam logic [9:0]  DELAY_MAX    = 10'h3e7;
  localparam logic [6:0]  LEVEL_RST    = 7'h00;
  localparam logic [9:0]  DELAY_RST    = 10'h005;

  // Input function codes
  typedef enum logic [3:0] {
    FN_NONE      = 4'h0,
    FN_FREEWHEEL = 4'h1,
    FN_EXT_FAULT = 4'h2,
    FN_PREHEAT   = 4'h3,
    FN_LOCAL     = 4'h4,
    FN_INHIBIT   = 4'h5,
    FN_THERM_RST = 4'h6,
    FN_CASCADE   = 4'h7,
    FN_FAULT_RST = 4'h8,
    FN_SECOND    = 4'h9
  } li_func_t;

  localparam li_func_t FUNC_A_RST = FN_FREEWHEEL;
  localparam li_func_t FUNC_B_RST = FN_LOCAL;

  // Preheat sequencer states
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WAIT = 2'b01,
    PH_HEAT = 2'b10
  } ph_state_t;

endpackage : starter_li_pkg

/* File: logic/sync_bits.sv */
// Purpose: Two-flop synchroniser for a group of asynchronous pins
// Assumes: Each bit is an independent level
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module sync_bits #(
  parameter int W = 3
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  // One pair of flops per bit
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta_r;
      logic hold_r;
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_r <= 1'b0;
          hold_r <= 1'b0;
        end
        else
        begin
          meta_r <= async_in[i];
          hold_r <= meta_r;
        end
      end
      assign sync_out[i] = hold_r;
    end
  endgenerate

endmodule : sync_bits
`default_nettype wire

/* File: logic/minute_timer.sv */
// Purpose: Counts whole minutes while enabled, from a derived tick
// Assumes: clear has priority over counting
// Notes:   Saturates at the top count so a long wait never wraps
`timescale 1ns/1ps
`default_nettype none
module minute_timer #(
  parameter logic [35:0] MINUTE_CYCLES = 36'd12_000_000_000
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic       clear,
  output logic      [9:0] minutes
);

  logic [35:0] tick_r;
  logic [35:0] tick_nxt;
  logic [9:0]  min_r;
  logic [9:0]  min_nxt;

  // Tick divider and minute count
  always_comb
  begin
    tick_nxt = tick_r;
    min_nxt  = min_r;
    if (clear)
    begin
      tick_nxt = 36'h0;
      min_nxt  = 10'h000;
    end
    else if (enable)
    begin
      if (tick_r == MINUTE_CYCLES - 36'd1)
      begin
        tick_nxt = 36'h0;
        if (min_r != 10'h3ff)
          min_nxt = min_r + 10'h001;
      end
      else
        tick_nxt = tick_r + 36'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_r <= 36'h0;
      min_r  <= 10'h000;
    end
    else
    begin
      tick_r <= tick_nxt;
      min_r  <= min_nxt;
    end
  end

  assign minutes = min_r;

endmodule : minute_timer
`default_nettype wire

/* File: logic/starter_logic_inputs.sv */
// Purpose: Assignable logic-input decoder and motor preheat sequencer
// Assumes: Motor, command and fault signals come from mclk logic
// Notes:   Wishbone classic slave, ack one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module starter_logic_inputs
  import starter_li_pkg::*;
#(
  parameter logic [31:0] HOLD_CYCLES   = CONFIRM_HOLD_CYC,
  parameter logic [35:0] MINUTE_CYCLES = MINUTE_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        assignable_input_a,
  input  wire logic        assignable_input_b,
  input  wire logic        confirm_key,
  input  wire logic        remote_terminal_active,
  input  wire logic        motor_stopped,
  input  wire logic        restart_delay_done,
  input  wire logic        braking_done,
  input  wire logic        term_run_cmd,
  input  wire logic        term_stop_cmd,
  input  wire logic        link_in_use,
  input  wire logic        link_run_cmd,
  input  wire logic        link_stop_cmd,
  input  wire logic        thermal_fault_event,
  input  wire logic        other_fault_event,
  output logic             run_cmd_sel,
  output logic             stop_cmd_sel,
  output logic             stop_type_freewheel,
  output logic             freewheel_stop,
  output logic             external_fault_code,
  output logic             protection_inhibit,
  output logic             thermal_prot_off,
  output logic             second_param_set_select,
  output logic             preheat_active,
  output logic      [6:0]  preheat_current_level,
  output logic             first_relay,
  output logic             display_flash
);

  // Pins from the terminals are asynchronous
  logic [2:0] pin_s;
  logic       in_a;
  logic       in_b;
  logic       key_s;

  sync_bits #(.W(3)) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in ({confirm_key, assignable_input_b, assignable_input_a}),
    .sync_out (pin_s)
  );
  assign in_a  = pin_s[0];
  assign in_b  = pin_s[1];
  assign key_s = pin_s[2];

  // Register state
  li_func_t    func_a_r, func_a_nxt, func_b_r, func_b_nxt;
  li_func_t    pend_code_r, pend_code_nxt;
  logic        pend_b_r, pend_b_nxt, pend_r, pend_nxt;
  logic        csc_r, csc_nxt, iso_r, iso_nxt;
  logic [6:0]  level_r, level_nxt;
  logic [9:0]  delay_r, delay_nxt;
  logic        therm_r, therm_nxt, resf_r, resf_nxt;
  logic        flash_r, flash_nxt;
  logic [31:0] hold_r, hold_nxt;
  logic        ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic        trst_d_r, frst_d_r;

  // Function decode, active while its input is energized
  function automatic logic fn_on(input li_func_t f, input li_func_t fa,
                                 input li_func_t fb, input logic a,
                                 input logic b);
    fn_on = (fa == f && a) || (fb == f && b);
  endfunction : fn_on

  logic fw_on, ext_on, ph_on, loc_on, inh_on, trst_on, casc_on, frst_on;
  assign fw_on   = fn_on(FN_FREEWHEEL, func_a_r, func_b_r, in_a, in_b);
  assign ext_on  = fn_on(FN_EXT_FAULT, func_a_r, func_b_r, in_a, in_b);
  assign ph_on   = fn_on(FN_PREHEAT, func_a_r, func_b_r, in_a, in_b);
  assign loc_on  = fn_on(FN_LOCAL, func_a_r, func_b_r, in_a, in_b);
  assign inh_on  = fn_on(FN_INHIBIT, func_a_r, func_b_r, in_a, in_b);
  assign trst_on = fn_on(FN_THERM_RST, func_a_r, func_b_r, in_a, in_b);
  assign casc_on = fn_on(FN_CASCADE, func_a_r, func_b_r, in_a, in_b);
  assign frst_on = fn_on(FN_FAULT_RST, func_a_r, func_b_r, in_a, in_b);

  logic ph_assigned;
  assign ph_assigned = (func_a_r == FN_PREHEAT) || (func_b_r == FN_PREHEAT);

  // Command source selection
  always_comb
  begin
    if (link_in_use && !loc_on)
    begin
      run_cmd_sel  = link_run_cmd;
      stop_cmd_sel = link_stop_cmd;
    end
    else
    begin
      run_cmd_sel  = term_run_cmd;
      stop_cmd_sel = term_stop_cmd;
    end
  end

  // Stop type, fault stops and protection overrides
  logic fault_stop;
  assign stop_type_freewheel = fw_on;
  assign fault_stop = !inh_on && (ext_on || therm_r || resf_r);
  assign freewheel_stop = (fw_on && stop_cmd_sel) || fault_stop;
  assign external_fault_code     = ext_on;
  assign protection_inhibit      = inh_on;
  assign thermal_prot_off        = casc_on || inh_on;
  assign second_param_set_select = casc_on ? 1'b0 : fn_on(FN_SECOND,
    func_a_r, func_b_r, in_a, in_b);

  // Bus decode
  logic req, wr, rd;
  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr  = req && wb_we_i;
  assign rd  = req && !wb_we_i;

  // Checks one proposed assignment
  function automatic logic fn_ok(input logic [3:0] c, input logic comm_check_setting);
    fn_ok = (c <= 4'h9) &&
            !(comm_check_setting && (c == FN_FREEWHEEL || c == FN_PREHEAT));
  endfunction : fn_ok

  logic [3:0] wa, wb;
  logic       ph_state_run;
  assign wa = wb_dat_i[CFG_A_LSB +: 4];
  assign wb = wb_dat_i[CFG_B_LSB +: 4];

  // Register file, confirm hold and fault flags
  always_comb
  begin
    func_a_nxt    = func_a_r;
    func_b_nxt    = func_b_r;
    pend_code_nxt = pend_code_r;
    pend_b_nxt    = pend_b_r;
    pend_nxt      = pend_r;
    csc_nxt       = csc_r;
    iso_nxt       = iso_r;
    level_nxt     = level_r;
    delay_nxt     = delay_r;
    therm_nxt     = therm_r;
    resf_nxt      = resf_r;
    flash_nxt     = flash_r && key_s;
    hold_nxt      = 32'h0;
    ack_nxt       = req;
    dat_nxt       = 32'h0;
    if (wr && wb_adr_i == CONFIG_OFS && motor_stopped)
    begin
      if (wb_sel_i[0])
      begin
        if (wa != func_a_r && fn_ok(wa, csc_r))
        begin
          if (wa == FN_PREHEAT || wa == FN_INHIBIT)
          begin
            if (!remote_terminal_active)
            begin
              pend_nxt      = 1'b1;
              pend_b_nxt    = 1'b0;
              pend_code_nxt = li_func_t'(wa);
            end
          end
          else
            func_a_nxt = li_func_t'(wa);
        end
        if (wb != func_b_r && fn_ok(wb, csc_r))
        begin
          if (wb == FN_PREHEAT || wb == FN_INHIBIT)
          begin
            if (!remote_terminal_active)
            begin
              pend_nxt      = 1'b1;
              pend_b_nxt    = 1'b1;
              pend_code_nxt = li_func_t'(wb);
            end
          end
          else
            func_b_nxt = li_func_t'(wb);
        end
      end
      if (wb_sel_i[1])
      begin
        csc_nxt = wb_dat_i[CFG_CSC_BIT];
        iso_nxt = wb_dat_i[CFG_ISO_BIT];
      end
    end
    if (wr && wb_adr_i == PREHEAT_OFS && ph_assigned)
    begin
      if (wb_sel_i[0] && wb_dat_i[6:0] <= LEVEL_MAX)
        level_nxt = wb_dat_i[PH_LEVEL_LSB +: 7];
      if (wb_sel_i[2] && wb_sel_i[3] &&
          wb_dat_i[PH_DELAY_LSB +: 10] <= DELAY_MAX &&
          wb_dat_i[31:26] == 6'h00)
        delay_nxt = wb_dat_i[PH_DELAY_LSB +: 10];
    end
    // Confirm key must be held without a break
    if (pend_r && key_s && motor_stopped)
    begin
      hold_nxt = hold_r + 32'h1;
      if (hold_r >= HOLD_CYCLES - 32'h1)
      begin
        pend_nxt  = 1'b0;
        flash_nxt = 1'b1;
        hold_nxt  = 32'h0;
        if (pend_b_r)
          func_b_nxt = pend_code_r;
        else
          func_a_nxt = pend_code_r;
      end
    end
    // Software clear first, so an event in the same cycle still sets
    if (wr && wb_adr_i == FAULT_OFS && wb_sel_i[0])
    begin
      if (wb_dat_i[0])
        therm_nxt = 1'b0;
      if (wb_dat_i[1])
        resf_nxt = 1'b0;
    end
    if ((trst_on && !trst_d_r) || (frst_on && !frst_d_r))
      therm_nxt = 1'b0;
    if (frst_on && !frst_d_r)
      resf_nxt = 1'b0;
    if (thermal_fault_event && !casc_on)
      therm_nxt = 1'b1;
    if (other_fault_event)
      resf_nxt = 1'b1;
    // Read data
    if (rd)
    begin
      unique case (wb_adr_i)
        CONFIG_OFS:
          dat_nxt = {22'h0, iso_r, csc_r, func_b_r, func_a_r};
        PREHEAT_OFS:
          dat_nxt = ph_assigned ? {6'h0, delay_r, 9'h0, level_r}
                                : 32'h0;
        STATUS_OFS:
          dat_nxt = {16'h0, 2'b00, casc_on && !iso_r, ph_assigned,
                     pend_r, flash_r, first_relay, preheat_active,
                     frst_on, trst_on, casc_on, inh_on, loc_on, ph_on,
                     ext_on, fw_on};
        FAULT_OFS:
          dat_nxt = {29'h0, ext_on, resf_r, therm_r};
        default:
          dat_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      func_a_r    <= FUNC_A_RST;
      func_b_r    <= FUNC_B_RST;
      pend_code_r <= FN_NONE;
      pend_b_r    <= 1'b0;
      pend_r      <= 1'b0;
      csc_r       <= 1'b0;
      iso_r       <= 1'b0;
      level_r     <= LEVEL_RST;
      delay_r     <= DELAY_RST;
      therm_r     <= 1'b0;
      resf_r      <= 1'b0;
      flash_r     <= 1'b0;
      hold_r      <= 32'h0;
      ack_r       <= 1'b0;
      dat_r       <= 32'h0;
      trst_d_r    <= 1'b0;
      frst_d_r    <= 1'b0;
    end
    else
    begin
      func_a_r    <= func_a_nxt;
      func_b_r    <= func_b_nxt;
      pend_code_r <= pend_code_nxt;
      pend_b_r    <= pend_b_nxt;
      pend_r      <= pend_nxt;
      csc_r       <= csc_nxt;
      iso_r       <= iso_nxt;
      level_r     <= level_nxt;
      delay_r     <= delay_nxt;
      therm_r     <= therm_nxt;
      resf_r      <= resf_nxt;
      flash_r     <= flash_nxt;
      hold_r      <= hold_nxt;
      ack_r       <= ack_nxt;
      dat_r       <= dat_nxt;
      trst_d_r    <= trst_on;
      frst_d_r    <= frst_on;
    end
  end

  assign wb_ack_o      = ack_r;
  assign wb_dat_o      = dat_r;
  assign display_flash = flash_r;

  // Minute count runs only while stopped with the preheat input on
  logic [9:0] minutes;
  ph_state_t  ph_r, ph_nxt;
  logic       relay_r, relay_nxt;

  minute_timer #(.MINUTE_CYCLES(MINUTE_CYCLES)) u_min (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .enable  (ph_r == PH_WAIT),
    .clear   (!ph_on || !motor_stopped),
    .minutes (minutes)
  );

  // Preheat sequencer and isolating relay
  always_comb
  begin
    ph_nxt    = ph_r;
    relay_nxt = relay_r;
    unique case (ph_r)
      PH_IDLE:
        if (ph_on && motor_stopped && !run_cmd_sel && !stop_cmd_sel)
          ph_nxt = PH_WAIT;
      PH_WAIT:
        if (!ph_on || !motor_stopped || run_cmd_sel || stop_cmd_sel)
          ph_nxt = PH_IDLE;
        else if (minutes >= delay_r && restart_delay_done)
          ph_nxt = PH_HEAT;
      PH_HEAT:
        if (!ph_on || run_cmd_sel || stop_cmd_sel)
          ph_nxt = PH_IDLE;
    endcase
    // Non-isolating mode acts as a plain fault relay; braking_done is a
    // level, so run or heat must win over it or heating never closes
    if (!iso_r)
      relay_nxt = !fault_stop;
    else if (fault_stop)
      relay_nxt = 1'b0;
    else if (run_cmd_sel || ph_nxt == PH_HEAT)
      relay_nxt = 1'b1;
    else if (braking_done || freewheel_stop)
      relay_nxt = 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph_r    <= PH_IDLE;
      relay_r <= 1'b0;
    end
    else
    begin
      ph_r    <= ph_nxt;
      relay_r <= relay_nxt;
    end
  end

  assign ph_state_run          = (ph_r == PH_HEAT);
  assign preheat_active        = ph_state_run;
  assign preheat_current_level = ph_state_run ? level_r : 7'h00;
  assign first_relay           = relay_r;

endmodule : starter_logic_inputs
`default_nettype wire

/* File: test/starter_li_monitor.sv */
// Purpose: Port-level assertions for the starter logic-input block
// Assumes: One mclk domain, rst_n asynchronous and active low
// Notes:   Bound to the block at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module starter_li_monitor (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       restart_delay_done,
  input wire logic       run_cmd_sel,
  input wire logic       stop_cmd_sel,
  input wire logic       stop_type_freewheel,
  input wire logic       freewheel_stop,
  input wire logic       external_fault_code,
  input wire logic       protection_inhibit,
  input wire logic       preheat_active,
  input wire logic [6:0] preheat_current_level,
  input wire logic       first_relay
);
  // Single domain, so clock and reset are given once
  default clocking mon_cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // Bus answer timing
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("No ack one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Ack longer than one cycle");
  // Stop type and fault stops
  stop_type_a: assert property (stop_type_freewheel && stop_cmd_sel
    |-> freewheel_stop) else $error("Stop did not coast");
  ext_fault_a: assert property (
    external_fault_code && !protection_inhibit |-> freewheel_stop)
    else $error("External fault without coasting stop");
  relay_fault_a: assert property (
    external_fault_code && !protection_inhibit |=> !first_relay)
    else $error("Relay held through a fault");
  // Preheat start, end and current
  heat_start_a: assert property ($rose(preheat_active)
    |-> $past(restart_delay_done)) else $error("Heating too early");
  heat_end_a: assert property (
    preheat_active && (run_cmd_sel || stop_cmd_sel) |=> !preheat_active)
    else $error("Heating outlived a command");
  heat_level_a: assert property (!preheat_active
    |-> preheat_current_level == 7'h00) else $error("Current when idle");

  // Main scenarios reached
  cover property ($rose(preheat_active));
  cover property (external_fault_code && freewheel_stop);
  cover property (stop_type_freewheel && stop_cmd_sel);
endmodule : starter_li_monitor

bind starter_logic_inputs starter_li_monitor starter_li_monitor_inst (.*);
`default_nettype wire

/* File: test/motor_model.sv */
// Purpose: Behavioural motor and restart-delay timing at the far side
// Assumes: Run command arrives already selected by the block
// Notes:   Coasts SPIN_CYC cycles; restart delay runs from standstill
`timescale 1ns/1ps
`default_nettype none
module motor_model #(
  parameter int SPIN_CYC    = 6,
  parameter int RESTART_CYC = 8
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic run_cmd_sel,
  output logic      motor_stopped,
  output logic      restart_delay_done,
  output logic      braking_done
);
  int spin;
  int rest;
  // A run spins the motor up and restarts the restart delay
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      spin <= 0;
      rest <= 0;
    end
    else
    begin
      spin <= run_cmd_sel ? SPIN_CYC : (spin > 0 ? spin - 1 : 0);
      rest <= (spin != 0) ? 0 : (rest < RESTART_CYC ? rest + 1 : rest);
    end
  end
  // Heating never turns the shaft, so standstill follows spin only
  assign motor_stopped      = (spin == 0);
  assign restart_delay_done = (rest == RESTART_CYC);
  assign braking_done       = (spin == 0);
endmodule : motor_model
`default_nettype wire

/* File: test/starter_logic_inputs_tb_top.sv */
// Purpose: Self-checking bench for the starter logic-input block
// Assumes: Short hold and minute counts; motor_model on the far side
// Notes:   Registers reached by classic Wishbone single cycles
`timescale 1ns/1ps
`default_nettype none
module starter_logic_inputs_tb_top
  import starter_li_pkg::*;
;
  localparam logic [31:0] HOLD = 32'h0000_0014;
  localparam logic [35:0] MINC = 36'h0_0000_000a;
  localparam int          HEAT = 2 * int'(MINC);
  logic        mclk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        assignable_input_a, assignable_input_b, confirm_key;
  logic        remote_terminal_active, motor_stopped, restart_delay_done;
  logic        braking_done, term_run_cmd, term_stop_cmd, link_in_use;
  logic        link_run_cmd, link_stop_cmd, thermal_fault_event;
  logic        other_fault_event, run_cmd_sel, stop_cmd_sel, freewheel_stop;
  logic        stop_type_freewheel, external_fault_code, protection_inhibit;
  logic        thermal_prot_off, second_param_set_select, preheat_active;
  logic        first_relay, display_flash;
  logic [6:0]  preheat_current_level;
  int          err_total, checks, n;

  // Block under test with shortened counts, and its motor
  starter_logic_inputs #(.HOLD_CYCLES(HOLD), .MINUTE_CYCLES(MINC))
  starter_logic_inputs_inst (.*);
  motor_model motor_model_inst (.*);

  // 200 MHz clock
  initial
  begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic cyc(input int c);
    repeat (c) @(posedge mclk);
  endtask : cyc

  // Compare and count; an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle, held until ack is sampled high
  task automatic wb_acc(input logic we, input logic [3:0] adr,
                        input logic [31:0] dat);
    int k;
    k = 0;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    @(posedge mclk);
    // Only the watchdog ends a missing answer
    while (wb_ack_o !== 1'h1)
    begin
      @(posedge mclk);
      k++;
    end
    chk(32'(k), 32'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge mclk);
  endtask : wb_acc

  task automatic rdc(input logic [3:0] adr, input logic [31:0] exp);
    wb_acc(1'h0, adr, 32'h0);
    chk(rd, exp);
  endtask : rdc

  // Cycles until heating starts; never sooner than the set delay
  task automatic wait_heat;
    n = 0;
    while (preheat_active !== 1'h1 && n < 80)
    begin
      cyc(1);
      n++;
    end
    chk(32'(n >= HEAT && n < 80), 32'h1);
  endtask : wait_heat

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  // Hang guard, far beyond the expected run
  initial
  begin
    repeat (6000) @(posedge mclk);
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    test_done();
  end

  // Test sequence
  initial
  begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, confirm_key} = 5'h00;
    {assignable_input_a, assignable_input_b, remote_terminal_active} = 3'h0;
    {term_run_cmd, term_stop_cmd, link_in_use, link_run_cmd} = 4'h0;
    {link_stop_cmd, thermal_fault_event, other_fault_event} = 3'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = {4'h0, 4'hf, 32'h0};
    err_total = 0;
    checks = 0;
    cyc(6);
    rst_n <= 1'h1;
    cyc(2);
    rdc(CONFIG_OFS, {24'h0, FUNC_B_RST, FUNC_A_RST});
    rdc(PREHEAT_OFS, 32'h0);
    assignable_input_a <= 1'h1;
    cyc(4);
    chk(32'(freewheel_stop), 32'h0);
    term_stop_cmd <= 1'h1;
    cyc(2);
    chk(32'(freewheel_stop), 32'h1);
    term_stop_cmd <= 1'h0;
    assignable_input_a <= 1'h0;
    wb_acc(1'h1, CONFIG_OFS, 32'h42);
    assignable_input_a <= 1'h1;
    cyc(4);
    chk(32'(external_fault_code), 32'h1);
    assignable_input_a <= 1'h0;
    cyc(4);
    wb_acc(1'h1, FAULT_OFS, 32'h3);
    $display("Test input functions done");
    link_in_use <= 1'h1;
    link_run_cmd <= 1'h1;
    cyc(4);
    chk(32'(run_cmd_sel), 32'h1);
    wb_acc(1'h1, CONFIG_OFS, 32'h92);
    rdc(CONFIG_OFS, 32'h42);
    assignable_input_b <= 1'h1;
    cyc(4);
    chk(32'(run_cmd_sel), 32'h0);
    {link_run_cmd, link_in_use, assignable_input_b} <= 3'h0;
    cyc(12);
    wb_acc(1'h1, CONFIG_OFS, 32'h192);
    wb_acc(1'h1, CONFIG_OFS, 32'h193);
    rdc(CONFIG_OFS, 32'h192);
    $display("Test assignment rules done");
    wb_acc(1'h1, CONFIG_OFS, 32'h292);
    wb_acc(1'h1, CONFIG_OFS, 32'h293);
    rdc(CONFIG_OFS, 32'h292);
    confirm_key <= 1'h1;
    cyc(int'(HOLD) + 6);
    chk(32'(display_flash), 32'h1);
    confirm_key <= 1'h0;
    rdc(CONFIG_OFS, 32'h293);
    rdc(PREHEAT_OFS, 32'h0005_0000);
    wb_acc(1'h1, PREHEAT_OFS, 32'h0005_0065);
    wb_acc(1'h1, PREHEAT_OFS, 32'h03e8_0000);
    rdc(PREHEAT_OFS, 32'h0005_0000);
    wb_acc(1'h1, PREHEAT_OFS, 32'h0002_0064);
    rdc(PREHEAT_OFS, 32'h0002_0064);
    $display("Test preheat settings done");
    assignable_input_a <= 1'h1;
    wait_heat();
    chk({25'h0, preheat_current_level}, 32'h64);
    chk(32'(first_relay), 32'h1);
    term_run_cmd <= 1'h1;
    cyc(3);
    chk(32'(preheat_active), 32'h0);
    term_run_cmd <= 1'h0;
    wait_heat();
    assignable_input_a <= 1'h0;
    cyc(4);
    chk(32'(preheat_active), 32'h0);
    $display("Test preheat sequence done");
    wb_acc(1'h1, CONFIG_OFS, 32'h263);
    {thermal_fault_event, other_fault_event} <= 2'h3;
    cyc(1);
    {thermal_fault_event, other_fault_event} <= 2'h0;
    rdc(FAULT_OFS, 32'h3);
    assignable_input_b <= 1'h1;
    cyc(5);
    rdc(FAULT_OFS, 32'h2);
    assignable_input_b <= 1'h0;
    cyc(4);
    wb_acc(1'h1, CONFIG_OFS, 32'h283);
    rdc(FAULT_OFS, 32'h2);
    assignable_input_b <= 1'h1;
    cyc(5);
    rdc(FAULT_OFS, 32'h0);
    $display("Test fault resets done");
    wb_acc(1'h1, CONFIG_OFS, 32'h297);
    chk(32'(second_param_set_select), 32'h1);
    assignable_input_a <= 1'h1;
    cyc(4);
    chk(32'(thermal_prot_off), 32'h1);
    thermal_fault_event <= 1'h1;
    cyc(1);
    thermal_fault_event <= 1'h0;
    rdc(FAULT_OFS, 32'h0);
    wb_acc(1'h1, CONFIG_OFS, 32'h257);
    confirm_key <= 1'h1;
    cyc(int'(HOLD) + 6);
    confirm_key <= 1'h0;
    other_fault_event <= 1'h1;
    cyc(4);
    chk(32'(protection_inhibit), 32'h1);
    chk(32'(freewheel_stop), 32'h0);
    other_fault_event <= 1'h0;
    $display("Test protection overrides done");
    test_done();
  end
endmodule : starter_logic_inputs_tb_top
`default_nettype wire
